// File: include/lhg_defs.svh
// Offsets, field positions, reset values and timing counts for the LAN host glue.
`ifndef LHG_DEFS_SVH
`define LHG_DEFS_SVH
`define LHG_OFF_HRST 32'h0000_0000
`define LHG_OFF_PORT 32'h0000_0004
`define LHG_OFF_ATTN 32'h0000_0008
`define LHG_OFF_IORST 32'h0010_C00C
`define LHG_IORST_NET 0
`define LHG_IORST_RST 32'h0000_0000
`define LHG_HRST_CYCLES 8'h10
`define LHG_SYS_NS 8
`define LHG_TX_NS 100
`define LHG_GUARD_SYS 10
`define LHG_GUARD_TX 5
`define LHG_GUARD_CYC (`LHG_GUARD_SYS + (`LHG_GUARD_TX * `LHG_TX_NS + `LHG_SYS_NS - 1) / `LHG_SYS_NS)
`define LHG_H_TARGET 8'h00
`define LHG_H_WR_GO 8'h04
`define LHG_H_RD_GO 8'h08
`define LHG_H_RESULT 8'h0C
`define LHG_H_STATUS 8'h10
`define LHG_H_CTRL 8'h14
`define LHG_H_MEM_IDX 8'h18
`define LHG_H_MEM_DATA 8'h1C
`define LHG_CTRL_BUSRST 0
`define LHG_CTRL_UNMASK 1
`endif

// File: include/lhg_pkg.sv
// State types for the two ends of the LAN host glue, one type for each end.
package lhg_pkg;
  typedef enum logic [3:0] {
    DMA_IDLE = 4'h1,
    DMA_REQ = 4'h2,
    DMA_ADDR = 4'h4,
    DMA_DATA = 4'h8
  } lhg_dma_t;
  typedef enum logic [4:0] {
    HST_IDLE = 5'h01,
    HST_WAIT = 5'h02,
    HST_ADDR = 5'h04,
    HST_DATA = 5'h08,
    HST_GRANT = 5'h10
  } lhg_hst_t;
endpackage

// File: include/lhg_if.sv
// Multiplexed host system bus between the host end and the glue end.
interface lhg_if;
  logic [31:0] host_ad;
  logic host_ad_oe;
  logic host_as;
  logic host_we;
  logic host_rdy;
  logic host_gnt;
  logic host_bus_reset_n;
  logic [31:0] glue_ad;
  logic glue_ad_oe;
  logic glue_as;
  logic glue_we;
  logic glue_rdy;
  logic glue_req;
  logic irq_n;
  logic [31:0] ad;
  // A floating bus reads as zero.
  assign ad = glue_ad_oe ? glue_ad : (host_ad_oe ? host_ad : 32'h0000_0000);
  modport glue (input host_as, host_we, host_rdy, host_gnt, host_bus_reset_n, ad,
                output glue_ad, glue_ad_oe, glue_as, glue_we, glue_rdy, glue_req, irq_n);
  modport host (input glue_as, glue_we, glue_rdy, glue_req, irq_n, ad,
                output host_ad, host_ad_oe, host_as, host_we, host_rdy, host_gnt,
                host_bus_reset_n);
endinterface

// File: core/lhg_port_latch.sv
// Pairs two half-word writes into one command word for the core.
`include "lhg_defs.svh"
module lhg_port_latch (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic wr_i,
  input wire logic [31:0] data_i,
  output logic [31:0] word_o,
  output logic valid_o
);
  logic half_ff, nxt_half;
  logic [15:0] hi_ff, nxt_hi;
  logic [31:0] word_ff, nxt_word;
  logic valid_ff, nxt_valid;

  always_comb begin
    nxt_half = half_ff;
    nxt_hi = hi_ff;
    nxt_word = word_ff;
    nxt_valid = 1'b0;
    if (clear_i) begin
      nxt_half = 1'b0;
    end else if (wr_i) begin
      if (!half_ff) begin
        nxt_hi = data_i[15:0];
        nxt_half = 1'b1;
      end else begin
        nxt_word = {hi_ff, data_i[15:0]};
        nxt_valid = 1'b1;
        nxt_half = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      half_ff <= 1'b0;
      hi_ff <= 16'h0000;
      word_ff <= 32'h0000_0000;
      valid_ff <= 1'b0;
    end else begin
      half_ff <= nxt_half;
      hi_ff <= nxt_hi;
      word_ff <= nxt_word;
      valid_ff <= nxt_valid;
    end
  end

  assign word_o = word_ff;
  assign valid_o = valid_ff;
endmodule // lhg_port_latch

// File: core/lhg_glue.sv
// Device end: joins the network controller core to the multiplexed host bus.
//
// Decided for this implementation: strobed register access.
`include "lhg_defs.svh"
module lhg_glue #(
  parameter logic [31:0] BASE_ADDR = 32'h0000_0000,
  parameter logic [7:0] HRST_CYCLES = `LHG_HRST_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_i,
  lhg_if.glue bus,
  input wire logic power_on_i,
  input wire logic primary_i,
  input wire logic core_int_n_i,
  input wire logic core_hold_i,
  input wire logic core_we_i,
  input wire logic [1:0] core_chan_i,
  input wire logic [31:0] core_addr_i,
  input wire logic [31:0] core_wdata_i,
  output logic core_reset_o,
  output logic attention_o,
  output logic first_attention_o,
  output logic [31:0] cmd_word_o,
  output logic cmd_valid_o,
  output logic core_hlda_o,
  output logic core_ack_o,
  output logic [1:0] dma_chan_o,
  output logic [31:0] core_rdata_o
);
  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    return a == BASE_ADDR + off;
  endfunction

  lhg_pkg::lhg_dma_t dma_ff, nxt_dma;
  logic strap_done_ff, nxt_strap_done;
  logic primary_ff, nxt_primary;
  logic tgt_ff, nxt_tgt;
  logic tgt_we_ff, nxt_tgt_we;
  logic [31:0] tgt_addr_ff, nxt_tgt_addr;
  logic [31:0] iorst_ff, nxt_iorst;
  logic [7:0] hrst_ff, nxt_hrst;
  logic reset_ff, nxt_reset;
  logic att_ff, nxt_att;
  logic first_ff, nxt_first;
  logic first_pend_ff, nxt_first_pend;
  logic rdy_ff, nxt_rdy;
  logic [31:0] ad_ff, nxt_ad;
  logic ad_oe_ff, nxt_ad_oe;
  logic as_ff, nxt_as;
  logic we_ff, nxt_we;
  logic req_ff, nxt_req;
  logic hlda_ff, nxt_hlda;
  logic ack_ff, nxt_ack;
  logic [1:0] chan_ff, nxt_chan;
  logic [31:0] rdata_ff, nxt_rdata;
  logic irq_n_ff, nxt_irq_n;
  logic wr;
  logic port_wr;
  logic claim;

  assign wr = tgt_ff && tgt_we_ff;
  // The paired word reaches the core as one pulse, so a port reset acts at once.
  assign port_wr = wr && hit(tgt_addr_ff, `LHG_OFF_PORT) && !reset_ff;
  assign claim = hit(bus.ad, `LHG_OFF_HRST) || hit(bus.ad, `LHG_OFF_PORT)
      || hit(bus.ad, `LHG_OFF_ATTN) || hit(bus.ad, `LHG_OFF_IORST);

  // The pairing restarts on every core reset so a half command never leaks across it.
  lhg_port_latch u_port (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .clear_i(reset_ff),
    .wr_i(port_wr),
    .data_i(bus.ad),
    .word_o(cmd_word_o),
    .valid_o(cmd_valid_o)
  );

  // Host access decode and core reset sources.
  always_comb begin
    nxt_strap_done = 1'b1;
    nxt_primary = strap_done_ff ? primary_ff : primary_i;
    nxt_tgt = bus.host_as && claim;
    nxt_tgt_we = bus.host_as ? bus.host_we : tgt_we_ff;
    nxt_tgt_addr = bus.host_as ? bus.ad : tgt_addr_ff;
    nxt_rdy = bus.host_as && claim;
    nxt_iorst = iorst_ff;
    nxt_hrst = (hrst_ff != 8'h00) ? hrst_ff - 8'h01 : hrst_ff;
    nxt_att = 1'b0;
    nxt_first = 1'b0;
    nxt_first_pend = first_pend_ff;
    if (wr && hit(tgt_addr_ff, `LHG_OFF_HRST)) begin
      nxt_hrst = HRST_CYCLES;
    end
    if (wr && hit(tgt_addr_ff, `LHG_OFF_IORST)) begin
      nxt_iorst = bus.ad;
    end
    // Attention carries no data; during core reset it is dropped.
    if (wr && hit(tgt_addr_ff, `LHG_OFF_ATTN) && !reset_ff) begin
      nxt_att = 1'b1;
      nxt_first = first_pend_ff;
      nxt_first_pend = 1'b0;
    end
    // No timing check against the reset-to-attention wait is made here.
    // Reset is held until the strap is known, so release never shows a one-cycle gap.
    nxt_reset = !strap_done_ff || (primary_ff ? power_on_i : !bus.host_bus_reset_n)
        || (hrst_ff != 8'h00) || iorst_ff[`LHG_IORST_NET];
    if (reset_ff) begin
      nxt_first_pend = 1'b1;
    end
    // Only reset is driven to the core; self-test has no path from here.
    nxt_irq_n = core_int_n_i;
  end

  // DMA master on behalf of the core; one bus access per grant.
  always_comb begin
    nxt_dma = dma_ff;
    nxt_as = 1'b0;
    nxt_we = we_ff;
    nxt_ad = ad_ff;
    nxt_ad_oe = 1'b0;
    nxt_req = req_ff;
    nxt_ack = 1'b0;
    nxt_chan = chan_ff;
    nxt_rdata = rdata_ff;
    unique case (dma_ff)
      lhg_pkg::DMA_IDLE: begin
        // The hold seen beside the answer belongs to the access that just ended.
        if (core_hold_i && !reset_ff && !ack_ff) begin
          nxt_dma = lhg_pkg::DMA_REQ;
          nxt_req = 1'b1;
        end
      end
      lhg_pkg::DMA_REQ: begin
        if (reset_ff) begin
          nxt_dma = lhg_pkg::DMA_IDLE;
          nxt_req = 1'b0;
        end else if (bus.host_gnt) begin
          nxt_dma = lhg_pkg::DMA_ADDR;
          nxt_as = 1'b1;
          nxt_we = core_we_i;
          nxt_ad = core_addr_i;
          nxt_ad_oe = 1'b1;
          nxt_chan = core_chan_i;
        end
      end
      lhg_pkg::DMA_ADDR: begin
        nxt_dma = lhg_pkg::DMA_DATA;
        nxt_ad = core_wdata_i;
        nxt_ad_oe = we_ff;
      end
      lhg_pkg::DMA_DATA: begin
        nxt_ad_oe = we_ff;
        if (bus.host_rdy) begin
          nxt_dma = lhg_pkg::DMA_IDLE;
          nxt_ad_oe = 1'b0;
          nxt_req = 1'b0;
          nxt_ack = !reset_ff;
          nxt_rdata = bus.ad;
        end
      end
    endcase
    // The glue answers host reads of the reset register when it does not own the bus.
    if (bus.host_as && !bus.host_we && hit(bus.ad, `LHG_OFF_IORST)) begin
      nxt_ad = iorst_ff;
      nxt_ad_oe = 1'b1;
    end
    nxt_hlda = (nxt_dma == lhg_pkg::DMA_ADDR) || (nxt_dma == lhg_pkg::DMA_DATA);
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      dma_ff <= lhg_pkg::DMA_IDLE;
      strap_done_ff <= 1'b0;
      primary_ff <= 1'b1;
      tgt_ff <= 1'b0;
      tgt_we_ff <= 1'b0;
      tgt_addr_ff <= 32'h0000_0000;
      iorst_ff <= `LHG_IORST_RST;
      hrst_ff <= 8'h00;
      reset_ff <= 1'b1;
      att_ff <= 1'b0;
      first_ff <= 1'b0;
      first_pend_ff <= 1'b1;
      rdy_ff <= 1'b0;
      ad_ff <= 32'h0000_0000;
      ad_oe_ff <= 1'b0;
      as_ff <= 1'b0;
      we_ff <= 1'b0;
      req_ff <= 1'b0;
      hlda_ff <= 1'b0;
      ack_ff <= 1'b0;
      chan_ff <= 2'h0;
      rdata_ff <= 32'h0000_0000;
      irq_n_ff <= 1'b1;
    end else begin
      dma_ff <= nxt_dma;
      strap_done_ff <= nxt_strap_done;
      primary_ff <= nxt_primary;
      tgt_ff <= nxt_tgt;
      tgt_we_ff <= nxt_tgt_we;
      tgt_addr_ff <= nxt_tgt_addr;
      iorst_ff <= nxt_iorst;
      hrst_ff <= nxt_hrst;
      reset_ff <= nxt_reset;
      att_ff <= nxt_att;
      first_ff <= nxt_first;
      first_pend_ff <= nxt_first_pend;
      rdy_ff <= nxt_rdy;
      ad_ff <= nxt_ad;
      ad_oe_ff <= nxt_ad_oe;
      as_ff <= nxt_as;
      we_ff <= nxt_we;
      req_ff <= nxt_req;
      hlda_ff <= nxt_hlda;
      ack_ff <= nxt_ack;
      chan_ff <= nxt_chan;
      rdata_ff <= nxt_rdata;
      irq_n_ff <= nxt_irq_n;
    end
  end

  assign bus.glue_ad = ad_ff;
  assign bus.glue_ad_oe = ad_oe_ff;
  assign bus.glue_as = as_ff;
  assign bus.glue_we = we_ff;
  assign bus.glue_rdy = rdy_ff;
  assign bus.glue_req = req_ff;
  assign bus.irq_n = irq_n_ff;
  assign core_reset_o = reset_ff;
  assign attention_o = att_ff;
  assign first_attention_o = first_ff;
  assign core_hlda_o = hlda_ff;
  assign core_ack_o = ack_ff;
  assign dma_chan_o = chan_ff;
  assign core_rdata_o = rdata_ff;
endmodule // lhg_glue

// File: core/lhg_host.sv
// Host end: issues bus writes and reads for software and serves core DMA from memory.
`include "lhg_defs.svh"
module lhg_host #(
  parameter int MEM_WORDS = 64,
  parameter logic [7:0] GUARD_CYCLES = 8'(`LHG_GUARD_CYC)
) (
  input wire logic clock_i,
  input wire logic rst_i,
  lhg_if.host bus,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o
);
  localparam int AW = $clog2(MEM_WORDS);
  logic [31:0] mem [MEM_WORDS];
  lhg_pkg::lhg_hst_t st_ff, nxt_st;
  logic [31:0] target_ff, nxt_target, wdata_ff, nxt_wdata, result_ff, nxt_result;
  logic [31:0] ad_ff, nxt_ad, rdata_ff, nxt_rdata;
  logic [AW-1:0] idx_ff, nxt_idx, dma_idx_ff, nxt_dma_idx;
  logic [1:0] ctrl_ff, nxt_ctrl;
  logic [7:0] guard_ff, nxt_guard;
  logic pend_ff, nxt_pend, pwe_ff, nxt_pwe, err_ff, nxt_err, irq_ff, nxt_irq;
  logic oe_ff, nxt_oe, as_ff, nxt_as, rdy_ff, nxt_rdy, gnt_ff, nxt_gnt;
  logic dwe_ff, nxt_dwe, dphase_ff, nxt_dphase, guarded;

  assign guarded = (target_ff == `LHG_OFF_ATTN) && (guard_ff != 8'h00);

  always_comb begin
    nxt_st = st_ff;
    nxt_target = target_ff;
    nxt_wdata = wdata_ff;
    nxt_result = result_ff;
    nxt_idx = idx_ff;
    nxt_ctrl = ctrl_ff;
    nxt_guard = (guard_ff != 8'h00) ? guard_ff - 8'h01 : guard_ff;
    nxt_pend = pend_ff;
    nxt_pwe = pwe_ff;
    nxt_err = err_ff;
    nxt_ad = ad_ff;
    nxt_oe = 1'b0;
    nxt_as = 1'b0;
    nxt_rdy = 1'b0;
    nxt_gnt = gnt_ff;
    nxt_dwe = dwe_ff;
    nxt_dma_idx = dma_idx_ff;
    nxt_dphase = 1'b0;
    nxt_rdata = 32'h0000_0000;
    unique case (reg_addr_i)
      `LHG_H_RESULT: nxt_rdata = result_ff;
      `LHG_H_STATUS: nxt_rdata = {22'h0, guard_ff, irq_ff, err_ff};
      `LHG_H_CTRL: nxt_rdata = {30'h0, ctrl_ff};
      `LHG_H_MEM_DATA: nxt_rdata = mem[idx_ff];
      default: nxt_rdata = 32'h0000_0000;
    endcase
    if (!reg_rd_i) begin
      nxt_rdata = 32'h0000_0000;
    end
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `LHG_H_TARGET: nxt_target = reg_wdata_i;
        `LHG_H_WR_GO: {nxt_pend, nxt_pwe, nxt_wdata} = {2'b11, reg_wdata_i};
        `LHG_H_RD_GO: {nxt_pend, nxt_pwe} = 2'b10;
        `LHG_H_CTRL: nxt_ctrl = reg_wdata_i[1:0];
        `LHG_H_MEM_IDX: nxt_idx = reg_wdata_i[AW-1:0];
        default: nxt_err = err_ff;
      endcase
    end
    if (ctrl_ff[`LHG_CTRL_BUSRST]) begin
      nxt_guard = GUARD_CYCLES;
    end
    unique case (st_ff)
      lhg_pkg::HST_IDLE, lhg_pkg::HST_WAIT: begin
        if (pend_ff && !guarded) begin
          nxt_st = lhg_pkg::HST_ADDR;
          nxt_as = 1'b1;
          nxt_ad = target_ff;
          nxt_oe = 1'b1;
          nxt_pend = 1'b0;
        end else if (pend_ff) begin
          nxt_st = lhg_pkg::HST_WAIT;
        end else if (bus.glue_req) begin
          nxt_st = lhg_pkg::HST_GRANT;
          nxt_gnt = 1'b1;
        end
      end
      lhg_pkg::HST_ADDR: begin
        nxt_st = lhg_pkg::HST_DATA;
        nxt_ad = wdata_ff;
        nxt_oe = pwe_ff;
      end
      lhg_pkg::HST_DATA: begin
        nxt_st = lhg_pkg::HST_IDLE;
        nxt_err = !bus.glue_rdy;
        if (!pwe_ff) begin
          nxt_result = bus.ad;
        end
        // Every reset path is followed by the settling wait before attention.
        if (pwe_ff && (target_ff == `LHG_OFF_HRST || target_ff == `LHG_OFF_PORT
            || target_ff == `LHG_OFF_IORST)) begin
          nxt_guard = GUARD_CYCLES;
        end
        if (pwe_ff && target_ff == `LHG_OFF_HRST) begin
          nxt_ctrl[`LHG_CTRL_UNMASK] = 1'b0;
        end
      end
      lhg_pkg::HST_GRANT: begin
        if (bus.glue_as) begin
          nxt_dma_idx = bus.ad[AW+1:2];
          nxt_dwe = bus.glue_we;
          nxt_rdy = 1'b1;
          nxt_dphase = 1'b1;
          nxt_ad = mem[bus.ad[AW+1:2]];
          nxt_oe = !bus.glue_we;
        end else if (!bus.glue_req && !dphase_ff) begin
          nxt_st = lhg_pkg::HST_IDLE;
          nxt_gnt = 1'b0;
        end
      end
    endcase
    nxt_irq = !bus.irq_n && ctrl_ff[`LHG_CTRL_UNMASK];
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= lhg_pkg::HST_IDLE;
      {target_ff, wdata_ff, result_ff, ad_ff, rdata_ff} <= {5{32'h0000_0000}};
      {idx_ff, dma_idx_ff} <= '0;
      ctrl_ff <= 2'h1;
      guard_ff <= 8'h00;
      {pend_ff, pwe_ff, err_ff, irq_ff, oe_ff, as_ff, rdy_ff, gnt_ff} <= 8'h00;
      {dwe_ff, dphase_ff} <= 2'h0;
    end else begin
      st_ff <= nxt_st;
      {target_ff, wdata_ff, result_ff, ad_ff, rdata_ff} <=
          {nxt_target, nxt_wdata, nxt_result, nxt_ad, nxt_rdata};
      {idx_ff, dma_idx_ff} <= {nxt_idx, nxt_dma_idx};
      ctrl_ff <= nxt_ctrl;
      guard_ff <= nxt_guard;
      {pend_ff, pwe_ff, err_ff, irq_ff} <= {nxt_pend, nxt_pwe, nxt_err, nxt_irq};
      {oe_ff, as_ff, rdy_ff, gnt_ff} <= {nxt_oe, nxt_as, nxt_rdy, nxt_gnt};
      {dwe_ff, dphase_ff} <= {nxt_dwe, nxt_dphase};
    end
  end

  // Shared memory holds the control blocks; software sets command word bit 7 here.
  always_ff @(posedge clock_i) begin
    if (reg_wr_i && reg_addr_i == `LHG_H_MEM_DATA) begin
      mem[idx_ff] <= reg_wdata_i;
    end else if (dphase_ff && dwe_ff) begin
      mem[dma_idx_ff] <= bus.ad;
    end
  end

  assign bus.host_ad = ad_ff;
  assign bus.host_ad_oe = oe_ff;
  assign bus.host_as = as_ff;
  assign bus.host_we = pwe_ff;
  assign bus.host_rdy = rdy_ff;
  assign bus.host_gnt = gnt_ff;
  assign bus.host_bus_reset_n = !ctrl_ff[`LHG_CTRL_BUSRST];
  assign reg_rdata_o = rdata_ff;
  assign irq_o = irq_ff;
endmodule // lhg_host

// File: verif/lhg_checker.sv
// Concurrent checks on the bus between the host end and the glue end.
`include "lhg_defs.svh"
module lhg_checker #(
  parameter int GUARD = `LHG_GUARD_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic host_as,
  input wire logic host_we,
  input wire logic host_rdy,
  input wire logic host_gnt,
  input wire logic host_bus_reset_n,
  input wire logic host_ad_oe,
  input wire logic glue_as,
  input wire logic glue_we,
  input wire logic glue_rdy,
  input wire logic glue_req,
  input wire logic glue_ad_oe,
  input wire logic [31:0] ad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mapped;
  logic [31:0] addr_ff;
  logic we_ff;
  int guard_ff;
  assign mapped = ad == `LHG_OFF_HRST || ad == `LHG_OFF_PORT || ad == `LHG_OFF_ATTN ||
    ad == `LHG_OFF_IORST;
  // The wait is counted from the answer, one cycle short, since the host may start at the strobe.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      addr_ff <= 32'h0;
      we_ff <= 1'h0;
      guard_ff <= 32'h0;
    end else begin
      if (host_as) begin
        addr_ff <= ad;
        we_ff <= host_we;
      end
      if (glue_rdy && we_ff && addr_ff != `LHG_OFF_ATTN) begin
        guard_ff <= GUARD - 1;
      end else if (guard_ff != 0) begin
        guard_ff <= guard_ff - 1;
      end
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_rdy_mapped: assert property (host_as && mapped |=> glue_rdy)
    else $error("mapped access not answered");
  a_rdy_unmapped: assert property (host_as && !mapped |=> !glue_rdy)
    else $error("unmapped access answered");
  a_rdy_cause: assert property (glue_rdy |-> $past(host_as))
    else $error("answer without strobe");
  a_as_granted: assert property (glue_as |-> host_gnt && glue_req && glue_ad_oe)
    else $error("glue strobe without grant");
  a_dma_answered: assert property (glue_as |=> host_rdy)
    else $error("dma cycle not answered");
  a_req_release: assert property (host_rdy |=> !glue_req)
    else $error("request held after answer");
  a_req_served: assert property ($rose(glue_req) |-> ##[2:200] (glue_as || !glue_req))
    else $error("request never served");
  a_gnt_follows: assert property (host_gnt |-> glue_req || $past(glue_req))
    else $error("grant without request");
  a_no_clash: assert property (!(glue_ad_oe && host_ad_oe))
    else $error("both ends drive the bus");
  a_dma_wdata: assert property (glue_as && glue_we |=> glue_ad_oe && !host_ad_oe)
    else $error("dma write data not driven");
  a_attn_guard: assert property (host_as && host_we && ad == `LHG_OFF_ATTN |->
    guard_ff == 0 && host_bus_reset_n)
    else $error("attention inside reset wait");
endmodule // lhg_checker

// File: verif/tb.sv
// Self-checking bench for both ends of the LAN host glue.
`include "lhg_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] HRST = 8'h06;
  logic clock_i = 1'h0;
  logic rst_i = 1'h1;
  logic power_on_i = 1'h0;
  logic primary_i = 1'h0;
  logic core_int_n_i = 1'h1;
  logic core_hold_i = 1'h0;
  logic core_we_i = 1'h0;
  logic [1:0] core_chan_i = 2'h0;
  logic [31:0] core_addr_i = 32'h0;
  logic [31:0] core_wdata_i = 32'h0;
  logic [7:0] reg_addr_i = 8'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'h0;
  logic reg_rd_i = 1'h0;
  logic core_reset_o, attention_o, first_attention_o, cmd_valid_o, core_hlda_o;
  logic core_ack_o, irq_o;
  logic [31:0] cmd_word_o, core_rdata_o, reg_rdata_o;
  logic [1:0] dma_chan_o;
  int bad_count = 0;
  int n_tests = 0;
  int n_cmd = 0;
  int n_hlda = 0;
  lhg_if bus_if ();
  always #4 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    if (cmd_valid_o === 1'h1) n_cmd <= n_cmd + 1;
    if (core_hlda_o === 1'h1) n_hlda <= n_hlda + 1;
  end
  lhg_glue #(.HRST_CYCLES(HRST)) lhg_glue_inst (.clock_i, .rst_i, .bus(bus_if), .power_on_i,
    .primary_i, .core_int_n_i, .core_hold_i, .core_we_i, .core_chan_i, .core_addr_i,
    .core_wdata_i, .core_reset_o, .attention_o, .first_attention_o, .cmd_word_o,
    .cmd_valid_o, .core_hlda_o, .core_ack_o, .dma_chan_o, .core_rdata_o);
  lhg_host lhg_host_inst (.clock_i, .rst_i, .bus(bus_if), .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o);
  lhg_checker #(.GUARD(`LHG_GUARD_CYC)) lhg_checker_inst (.clock_i, .rst_i,
    .host_as(bus_if.host_as), .host_we(bus_if.host_we), .host_rdy(bus_if.host_rdy),
    .host_gnt(bus_if.host_gnt), .host_bus_reset_n(bus_if.host_bus_reset_n),
    .host_ad_oe(bus_if.host_ad_oe), .glue_as(bus_if.glue_as), .glue_we(bus_if.glue_we),
    .glue_rdy(bus_if.glue_rdy), .glue_req(bus_if.glue_req),
    .glue_ad_oe(bus_if.glue_ad_oe), .ad(bus_if.ad));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("mismatches=%0d comparisons=%0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // The strobe is dropped a full cycle before the next request so no signal is set twice at once.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr_i <= 1'h1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'h0;
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_rd_i <= 1'h1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'h0;
    @(negedge clock_i);
    d = reg_rdata_o;
    @(posedge clock_i);
  endtask
  // Pulses are looked for at the falling edge, where every flop output has settled.
  task automatic wait_ev(input int sel, output logic hit);
    logic [5:0] v;
    hit = 1'h0;
    for (int i = 0; i < 300 && !hit; i++) begin
      @(negedge clock_i);
      v = {core_reset_o, !core_reset_o, core_ack_o, cmd_valid_o, attention_o, bus_if.glue_rdy};
      hit = v[sel] === 1'h1;
    end
  endtask
  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
    wr(`LHG_H_TARGET, a);
    wr(`LHG_H_WR_GO, d);
  endtask
  task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
    logic h;
    wr(`LHG_H_TARGET, a);
    wr(`LHG_H_RD_GO, 32'h0);
    wait_ev(0, h);
    repeat (2) @(posedge clock_i);
    rd(`LHG_H_RESULT, d);
  endtask
  task automatic t_reset();
    logic [31:0] d;
    logic h;
    chk(core_reset_o, 1'h1);
    rst_i <= 1'h0;
    @(posedge clock_i);
    @(negedge clock_i);
    chk(core_reset_o, 1'h1);
    @(posedge clock_i);
    rd(`LHG_H_CTRL, d);
    chk(d, 32'h1);
    chk(core_reset_o, 1'h1);
    wr(`LHG_H_CTRL, 32'h0);
    wait_ev(4, h);
    chk(h, 1'h1);
    @(posedge clock_i);
  endtask
  task automatic t_attn();
    logic h;
    for (int i = 0; i < 2; i++) begin
      bus_wr(`LHG_OFF_ATTN, 32'hFFFF_FFFF);
      wait_ev(1, h);
      chk(h, 1'h1);
      chk(first_attention_o, i == 0);
      @(posedge clock_i);
    end
  endtask
  task automatic t_port();
    int n;
    logic h;
    n = n_cmd;
    bus_wr(`LHG_OFF_PORT, 32'hABCD_1234);
    wait_ev(0, h);
    repeat (4) @(posedge clock_i);
    chk(n_cmd, n);
    bus_wr(`LHG_OFF_PORT, 32'h5678_9876);
    wait_ev(2, h);
    chk(h, 1'h1);
    chk(cmd_word_o, 32'h1234_9876);
    @(posedge clock_i);
  endtask
  task automatic t_hrst();
    logic h;
    int n;
    bus_wr(`LHG_OFF_PORT, 32'h0000_1111);
    bus_wr(`LHG_OFF_HRST, 32'h0);
    wait_ev(5, h);
    for (n = 1; n < 100 && core_reset_o === 1'h1; n++) @(negedge clock_i);
    chk(n - 1, HRST);
    @(posedge clock_i);
    bus_wr(`LHG_OFF_PORT, 32'h0000_2222);
    bus_wr(`LHG_OFF_PORT, 32'h0000_3333);
    wait_ev(2, h);
    chk(cmd_word_o, 32'h2222_3333);
    @(posedge clock_i);
    bus_wr(`LHG_OFF_ATTN, 32'h0);
    wait_ev(1, h);
    chk(first_attention_o, 1'h1);
    @(posedge clock_i);
  endtask
  task automatic t_iorst();
    logic [31:0] d;
    logic h;
    bus_wr(32'h0000_0040, 32'h5);
    repeat (8) @(posedge clock_i);
    rd(`LHG_H_STATUS, d);
    chk(d[0], 1'h1);
    bus_rd(`LHG_OFF_IORST, d);
    chk(d, `LHG_IORST_RST);
    rd(`LHG_H_STATUS, d);
    chk(d[0], 1'h0);
    bus_wr(`LHG_OFF_IORST, 32'h1);
    wait_ev(5, h);
    chk(h, 1'h1);
    @(posedge clock_i);
    bus_rd(`LHG_OFF_IORST, d);
    chk(d, 32'h1);
    bus_wr(`LHG_OFF_IORST, 32'h0);
    wait_ev(4, h);
    chk(h, 1'h1);
    @(posedge clock_i);
  endtask
  task automatic t_irq();
    core_int_n_i <= 1'h0;
    repeat (3) @(posedge clock_i);
    chk(irq_o, 1'h0);
    wr(`LHG_H_CTRL, 32'h2);
    repeat (3) @(posedge clock_i);
    chk(irq_o, 1'h1);
    core_int_n_i <= 1'h1;
    repeat (3) @(posedge clock_i);
    chk(irq_o, 1'h0);
  endtask
  task automatic t_dma();
    logic [31:0] d;
    logic h;
    for (int c = 0; c < 4; c++) begin
      wr(`LHG_H_MEM_IDX, c);
      wr(`LHG_H_MEM_DATA, 32'hA5A5_0000 + c);
    end
    for (int c = 0; c < 5; c++) begin
      int n0;
      n0 = n_hlda;
      core_hold_i <= 1'h1;
      core_we_i <= c == 4;
      core_chan_i <= c[1:0];
      core_addr_i <= (c == 4) ? 32'h20 : 32'(4 * c);
      core_wdata_i <= 32'h0BAD_F00D;
      wait_ev(3, h);
      chk(h, 1'h1);
      chk(dma_chan_o, c[1:0]);
      chk(n_hlda - n0, 2);
      if (c < 4) chk(core_rdata_o, 32'hA5A5_0000 + c);
      @(posedge clock_i);
      core_hold_i <= 1'h0;
      repeat (10) @(posedge clock_i);
    end
    wr(`LHG_H_MEM_IDX, 32'h8);
    rd(`LHG_H_MEM_DATA, d);
    chk(d, 32'h0BAD_F00D);
  endtask
  // A primary end must ignore the bus reset that the host still holds after its own reset.
  task automatic t_power();
    logic h;
    rst_i <= 1'h1;
    primary_i <= 1'h1;
    power_on_i <= 1'h1;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'h0;
    repeat (4) @(posedge clock_i);
    chk(core_reset_o, 1'h1);
    power_on_i <= 1'h0;
    wait_ev(4, h);
    chk(h, 1'h1);
  endtask
  initial begin
    repeat (10) @(posedge clock_i);
    t_reset();
    t_attn();
    t_port();
    t_hrst();
    t_iorst();
    t_irq();
    t_dma();
    t_power();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    bad_count++;
    summarize();
  end
endmodule // tb
